// File: rtl/wdc_pkg.sv
/*
  Shared constants and carriers of the watchdog counter with feed lock:
  control bit positions, reset values, unlock keys, counter limits and the
  write-strobe bundle from the special function register decoder.
  Assumes the surrounding core decodes its register addresses into the
  one-hot strobes of wdc_sfr_wr_s.
*/
package wdc_pkg;

  // ----------------------------------------------------------------------
  // control register layout
  // ----------------------------------------------------------------------
  localparam int CTRL_RUN_BIT     = 0;
  localparam int CTRL_REFRESH_BIT = 1;
  localparam int CTRL_OVF_BIT     = 2;
  localparam int CTRL_REEN_BIT    = 3;
  localparam int CTRL_FORCE_BIT   = 6;

  // ----------------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------------
  localparam logic       CTRL_RUN_RESET   = 1'h0;
  localparam logic       CTRL_FORCE_RESET = 1'h0;
  localparam logic       CTRL_REEN_RESET  = 1'h0;
  localparam logic       CTRL_OVF_RESET   = 1'h0;
  localparam logic [7:0] TBASE_RESET      = 8'h00;
  localparam logic [7:0] COUNT_RESET      = 8'h00;

  // ----------------------------------------------------------------------
  // unlock keys, counter limit, timing, vector
  // ----------------------------------------------------------------------
  localparam logic [7:0]  UNLOCK1_KEY             = 8'hFD;
  localparam logic [7:0]  UNLOCK2_KEY             = 8'h2A;
  localparam logic [7:0]  COUNT_LAST              = 8'hFE;
  localparam int unsigned PRESCALE_CYCLES_DEFAULT = 344064;
  localparam logic [7:0]  IRQ_VECTOR              = 8'h53;

  // ----------------------------------------------------------------------
  // types
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    FEED_IDLE,
    FEED_FIRST,
    FEED_ARMED
  } wdc_feed_e;

  typedef struct packed {
    logic       ctrl_wr;
    logic       tbase_wr;
    logic       unlock1_wr;
    logic       unlock2_wr;
    logic [7:0] data;
  } wdc_sfr_wr_s;

  typedef struct packed {
    logic run;
    logic force_on;
    logic reset_en;
    logic ovf;
  } wdc_ctrl_s;

endpackage

// File: rtl/wdc_top.sv
/*
  Watchdog counter with feed lock: control and time-base registers, the
  two-write unlock sequence, prescaler, 8-bit up counter, chip reset pulse
  and timer-mode interrupt request.
  Assumes one register write strobe per cycle, all inputs on clk_i, and
  that rst_b_i is the power-on reset of the chip.
*/
// Overview of operation
// - expiry with reset enable set starts a whole-chip hardware reset
// - reset enable, once set, is not cleared by writes; only power-on reset
// - with reset enable set, control writes need a correct unlock sequence first
// - force-on clear: run bit starts/stops; force-on set: counter runs regardless of run bit
// - writing one to refresh loads reload value and clears the prescaler
// - reload value is taken from the time-base register
// - watchdog reset lasts one watchdog clock period, then execution restarts
// - overflow sets sticky flag; cleared by power-on or unlocked write of one
// - in timer mode control and time-base writes need no unlock
// - in timer mode run bit set starts, clear stops the counter
// - in timer mode overflow sets flag, writing one clears it
// - in timer mode overflow reloads counter and counting resumes at once
// - enabled timer-mode overflow requests interrupt at vector 053H
// - counter steps once every 344064 system clocks via prescaler
// - time-out equals (255 minus reload) times 344064 clocks, one period for reload FFH
// - unlock: FDH to first register, 2AH to second, then control write
// - in watchdog mode a wrong unlock sequence resets the chip at once
// - counter runs during idle and halts during power-down
`timescale 1ns/1ns
module wdc_top #(
  parameter int unsigned PRESCALE_CYCLES = wdc_pkg::PRESCALE_CYCLES_DEFAULT
) (
  input  wire logic                clk_i,
  input  wire logic                rst_b_i,
  input  wire wdc_pkg::wdc_sfr_wr_s sfr_wr_i,
  input  wire logic                power_down_i,
  input  wire logic                wd_int_en_i,
  output logic [7:0]               ctrl_rdata_o,
  output logic [7:0]               tbase_rdata_o,
  output logic [7:0]               count_o,
  output logic                     chip_reset_o,
  output logic                     irq_o,
  output logic [7:0]               irq_vector_o
);

  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  localparam int          PW         = $clog2(PRESCALE_CYCLES);
  localparam logic [PW-1:0] PRESC_LAST = PW'(PRESCALE_CYCLES - 1);
  localparam logic [PW-1:0] PRESC_ZERO = '0;

  typedef struct packed {
    wdc_pkg::wdc_ctrl_s ctrl;
    logic [7:0]         tbase;
    logic [7:0]         count;
    logic [PW-1:0]      presc;
    wdc_pkg::wdc_feed_e feed;
    logic               rst_active;
  } wdc_state_s;

  wdc_state_s s_reg;
  wdc_state_s s_next;

  logic wd_mode;
  logic presc_done;
  logic counting;
  logic tick;
  logic ovf_evt;
  logic ctrl_ok;
  logic bad_feed;
  logic refresh;
  logic start_reset;

  // ----------------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------------
  always_comb begin
    s_next     = s_reg;
    wd_mode    = s_reg.ctrl.reset_en;
    presc_done = (s_reg.presc == PRESC_LAST);
    ctrl_ok    = 1'b0;
    bad_feed   = 1'b0;

    // unlock sequence; any unexpected step in watchdog mode is a bad feed
    if (wd_mode) begin
      unique case (s_reg.feed)
        wdc_pkg::FEED_IDLE: begin
          if (sfr_wr_i.unlock1_wr && sfr_wr_i.data == wdc_pkg::UNLOCK1_KEY) begin
            s_next.feed = wdc_pkg::FEED_FIRST;
          end else if (sfr_wr_i.unlock1_wr || sfr_wr_i.unlock2_wr || sfr_wr_i.ctrl_wr) begin
            bad_feed = 1'b1;
          end
        end
        wdc_pkg::FEED_FIRST: begin
          if (sfr_wr_i.unlock2_wr && sfr_wr_i.data == wdc_pkg::UNLOCK2_KEY) begin
            s_next.feed = wdc_pkg::FEED_ARMED;
          end else if (sfr_wr_i.unlock1_wr || sfr_wr_i.unlock2_wr || sfr_wr_i.ctrl_wr) begin
            bad_feed = 1'b1;
          end
        end
        wdc_pkg::FEED_ARMED: begin
          if (sfr_wr_i.ctrl_wr) begin
            ctrl_ok     = 1'b1;
            s_next.feed = wdc_pkg::FEED_IDLE;
          end else if (sfr_wr_i.unlock1_wr || sfr_wr_i.unlock2_wr) begin
            bad_feed = 1'b1;
          end
        end
      endcase
    end else begin
      ctrl_ok     = sfr_wr_i.ctrl_wr;
      s_next.feed = wdc_pkg::FEED_IDLE;
    end
    if (bad_feed) begin
      s_next.feed = wdc_pkg::FEED_IDLE;
    end

    // idle mode is not an input: the counter simply keeps running then
    counting = (s_reg.ctrl.run || s_reg.ctrl.force_on) && !power_down_i && !s_reg.rst_active;
    tick     = counting && presc_done;
    ovf_evt  = tick && (s_reg.count >= wdc_pkg::COUNT_LAST);
    refresh  = ctrl_ok && sfr_wr_i.data[wdc_pkg::CTRL_REFRESH_BIT];
    start_reset = (ovf_evt && wd_mode) || bad_feed;

    // prescaler doubles as the timer of the reset pulse
    if (s_reg.rst_active || counting) begin
      s_next.presc = presc_done ? PRESC_ZERO : s_reg.presc + PW'(1);
    end

    // counter
    if (tick) begin
      s_next.count = ovf_evt ? s_reg.tbase : s_reg.count + 8'h01;
    end
    if (s_reg.rst_active) begin
      s_next.count = s_reg.tbase;
    end
    if (refresh) begin
      s_next.count = s_reg.tbase;
      s_next.presc = PRESC_ZERO;
    end

    // control register write
    if (ctrl_ok) begin
      s_next.ctrl.run      = sfr_wr_i.data[wdc_pkg::CTRL_RUN_BIT];
      s_next.ctrl.force_on = s_reg.ctrl.force_on || sfr_wr_i.data[wdc_pkg::CTRL_FORCE_BIT];
      s_next.ctrl.reset_en = s_reg.ctrl.reset_en || sfr_wr_i.data[wdc_pkg::CTRL_REEN_BIT];
      if (sfr_wr_i.data[wdc_pkg::CTRL_OVF_BIT]) begin
        s_next.ctrl.ovf = 1'b0;
      end
    end
    // a set in the clearing cycle wins
    if (ovf_evt) begin
      s_next.ctrl.ovf = 1'b1;
    end

    // time-base write is never locked
    if (sfr_wr_i.tbase_wr) begin
      s_next.tbase = sfr_wr_i.data;
    end

    // chip reset pulse of one full prescaler period
    if (s_reg.rst_active && presc_done) begin
      s_next.rst_active = 1'b0;
    end
    if (start_reset) begin
      s_next.rst_active = 1'b1;
      s_next.presc      = PRESC_ZERO;
    end
  end

  // ----------------------------------------------------------------------
  // register
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      s_reg.ctrl.run      <= wdc_pkg::CTRL_RUN_RESET;
      s_reg.ctrl.force_on <= wdc_pkg::CTRL_FORCE_RESET;
      s_reg.ctrl.reset_en <= wdc_pkg::CTRL_REEN_RESET;
      s_reg.ctrl.ovf      <= wdc_pkg::CTRL_OVF_RESET;
      s_reg.tbase         <= wdc_pkg::TBASE_RESET;
      s_reg.count         <= wdc_pkg::COUNT_RESET;
      s_reg.presc         <= PRESC_ZERO;
      s_reg.feed          <= wdc_pkg::FEED_IDLE;
      s_reg.rst_active    <= 1'b0;
    end else begin
      s_reg <= s_next;
    end
  end

  // ----------------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------------
  always_comb begin
    ctrl_rdata_o                          = 8'h00;
    ctrl_rdata_o[wdc_pkg::CTRL_RUN_BIT]   = s_reg.ctrl.run;
    ctrl_rdata_o[wdc_pkg::CTRL_OVF_BIT]   = s_reg.ctrl.ovf;
    ctrl_rdata_o[wdc_pkg::CTRL_REEN_BIT]  = s_reg.ctrl.reset_en;
    ctrl_rdata_o[wdc_pkg::CTRL_FORCE_BIT] = s_reg.ctrl.force_on;
  end

  assign tbase_rdata_o = s_reg.tbase;
  assign count_o       = s_reg.count;
  assign chip_reset_o  = s_reg.rst_active;
  // in watchdog mode the overflow resets the chip instead of interrupting
  assign irq_o         = s_reg.ctrl.ovf && wd_int_en_i && !s_reg.ctrl.reset_en;
  assign irq_vector_o  = wdc_pkg::IRQ_VECTOR;

  // ----------------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);

  AST_EXPIRE_RESETS: assert property (
    ovf_evt && s_reg.ctrl.reset_en |=> chip_reset_o
  ) else $error("expiry in watchdog mode did not reset the chip");

  AST_REEN_STICKY: assert property (
    s_reg.ctrl.reset_en |=> s_reg.ctrl.reset_en
  ) else $error("reset enable cleared without power-on reset");

  AST_LOCKED_WRITE: assert property (
    s_reg.ctrl.reset_en && sfr_wr_i.ctrl_wr && s_reg.feed != wdc_pkg::FEED_ARMED
    |=> $stable(s_reg.ctrl.run) && $stable(s_reg.ctrl.force_on) && chip_reset_o
  ) else $error("control write without unlock was taken");

  AST_FORCE_RUNS: assert property (
    s_reg.ctrl.force_on && !power_down_i && !s_reg.rst_active && !refresh && !start_reset
    |=> s_reg.presc != $past(s_reg.presc)
  ) else $error("forced counter did not advance its prescaler");

  AST_REFRESH_LOAD: assert property (
    refresh && !start_reset |=> s_reg.count == $past(s_reg.tbase) && s_reg.presc == PRESC_ZERO
  ) else $error("refresh did not load reload value and clear prescaler");

  AST_TICK_PERIOD: assert property (
    tick |-> $past(s_reg.presc) == PRESC_LAST - PW'(1) || $past(s_reg.presc) == PRESC_LAST
  ) else $error("counter step not at end of prescaler period");

  AST_RESET_HOLD: assert property (
    $fell(chip_reset_o) |-> $past(s_reg.presc) == PRESC_LAST
  ) else $error("chip reset shorter than one watchdog clock period");

  AST_BAD_FEED: assert property (
    bad_feed |=> chip_reset_o && s_reg.feed == wdc_pkg::FEED_IDLE
  ) else $error("wrong unlock sequence did not reset the chip");

  AST_OVF_SET: assert property (
    ovf_evt |=> s_reg.ctrl.ovf [*2]
  ) else $error("overflow flag not set or not sticky");

  AST_TIMER_CLEAR: assert property (
    !s_reg.ctrl.reset_en && sfr_wr_i.ctrl_wr && sfr_wr_i.data[wdc_pkg::CTRL_OVF_BIT] && !ovf_evt
    |=> !s_reg.ctrl.ovf
  ) else $error("write of one did not clear the flag in timer mode");

  AST_TIMER_WRITE: assert property (
    !s_reg.ctrl.reset_en && sfr_wr_i.ctrl_wr
    |=> s_reg.ctrl.run == $past(sfr_wr_i.data[wdc_pkg::CTRL_RUN_BIT]) && !chip_reset_o
  ) else $error("timer-mode control write not taken directly");

  AST_TIMER_RELOAD: assert property (
    ovf_evt && !s_reg.ctrl.reset_en && !refresh |=> s_reg.count == $past(s_reg.tbase) && !chip_reset_o
  ) else $error("timer overflow did not reload the counter");

  AST_IRQ: assert property (
    ovf_evt && !s_reg.ctrl.reset_en && wd_int_en_i |=> irq_o || !wd_int_en_i
  ) else $error("enabled timer overflow raised no interrupt");

  AST_PD_HALT: assert property (
    power_down_i && !s_reg.rst_active && !refresh && !start_reset
    |=> $stable(s_reg.count) && $stable(s_reg.presc)
  ) else $error("counter moved during power-down");

  AST_STOPPED: assert property (
    !s_reg.ctrl.run && !s_reg.ctrl.force_on && !s_reg.rst_active && !refresh && !start_reset
    |=> $stable(s_reg.count)
  ) else $error("stopped counter moved");

endmodule

// File: verif/wdc_top_tb.sv
/*
  Self-checking bench of the watchdog counter with feed lock: timer mode,
  power-down, force-on, watchdog expiry, feed lock refusals, power-on reset.
  Assumes the design's own assertions sit in its body; runs a short prescaler.
*/
`timescale 1ns/1ns
module wdc_top_tb;
  // ----------------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------------
  localparam int unsigned PS = 4;  // short prescaler keeps the run brief
  localparam int          K_CTRL = 0;
  localparam int          K_TB = 1;
  localparam int          K_U1 = 2;
  localparam int          K_U2 = 3;
  logic                 clk_i        = 1'h0;
  logic                 rst_b_i      = 1'h0;
  wdc_pkg::wdc_sfr_wr_s sfr_wr_i     = '0;
  logic                 power_down_i = 1'h0;
  logic                 wd_int_en_i  = 1'h0;
  logic [7:0]           ctrl_rdata_o;
  logic [7:0]           tbase_rdata_o;
  logic [7:0]           count_o;
  logic [7:0]           irq_vector_o;
  logic                 chip_reset_o;
  logic                 irq_o;
  int                   n_errors     = 0;
  int                   n_checks     = 0;
  int                   n;

  always #25 clk_i = ~clk_i;

  wdc_top #(.PRESCALE_CYCLES(PS)) u_wdc_top (
    .clk_i        (clk_i),
    .rst_b_i      (rst_b_i),
    .sfr_wr_i     (sfr_wr_i),
    .power_down_i (power_down_i),
    .wd_int_en_i  (wd_int_en_i),
    .ctrl_rdata_o (ctrl_rdata_o),
    .tbase_rdata_o(tbase_rdata_o),
    .count_o      (count_o),
    .chip_reset_o (chip_reset_o),
    .irq_o        (irq_o),
    .irq_vector_o (irq_vector_o)
  );

  // ----------------------------------------------------------------------
  // helpers: every task starts and ends 1 ns after a rising edge
  // ----------------------------------------------------------------------
  task automatic conclude();
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp, input string msg);
    n_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected at %0t: %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask

  task automatic cyc(input int k);
    repeat (k) @(posedge clk_i);
    #1;
  endtask

  // strobe is cleared one cycle later and a free cycle follows, so no pin is set twice at once
  task automatic wr(input int k, input logic [7:0] d);
    sfr_wr_i.data       = d;
    sfr_wr_i.ctrl_wr    = (k == K_CTRL);
    sfr_wr_i.tbase_wr   = (k == K_TB);
    sfr_wr_i.unlock1_wr = (k == K_U1);
    sfr_wr_i.unlock2_wr = (k == K_U2);
    cyc(1);
    sfr_wr_i = '0;
    cyc(1);
  endtask

  task automatic feed();
    wr(K_U1, wdc_pkg::UNLOCK1_KEY);
    wr(K_U2, wdc_pkg::UNLOCK2_KEY);
  endtask

  // which 0: chip reset, 1: overflow flag; k counts cycles waited
  task automatic wait_sig(input int which, input logic lvl, input int lim, output int k);
    k = 0;
    while (((which == 0) ? chip_reset_o : ctrl_rdata_o[2]) !== lvl) begin
      if (k == lim) begin
        n_errors++;
        $display("unexpected at %0t: wait ran out", $time);
        conclude();
      end
      cyc(1);
      k++;
    end
  endtask

  // ----------------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------------
  task automatic t_reset();
    chk(ctrl_rdata_o, 8'h00, "control after reset");
    chk({6'h00, chip_reset_o, irq_o}, 8'h00, "reset and irq idle");
    chk(irq_vector_o, 8'h53, "vector");
  endtask

  task automatic t_timer();
    wd_int_en_i = 1'h1;
    wr(K_TB, 8'hFC);
    chk(tbase_rdata_o, 8'hFC, "time base write");
    wr(K_CTRL, 8'h03);
    chk(count_o, 8'hFC, "refresh load");
    chk(ctrl_rdata_o, 8'h01, "run bit");
    wait_sig(1, 1'h1, 30, n);
    chk(8'(n), 8'h0B, "overflow time");
    chk(count_o, 8'hFC, "reload on overflow");
    chk({7'h00, irq_o}, 8'h01, "irq on overflow");
    wd_int_en_i = 1'h0;
    cyc(1);
    chk({7'h00, irq_o}, 8'h00, "irq masked");
    cyc(3);
    chk(count_o, 8'hFD, "counting resumes");
    wr(K_CTRL, 8'h05);
    chk(ctrl_rdata_o, 8'h01, "flag cleared");
    wr(K_CTRL, 8'h00);
    n = count_o;
    cyc(12);
    chk(count_o, 8'(n), "stopped");
  endtask

  task automatic t_power_down();
    wr(K_CTRL, 8'h03);
    power_down_i = 1'h1;
    cyc(12);
    chk(count_o, 8'hFC, "frozen in power-down");
    power_down_i = 1'h0;
    cyc(9);
    chk(count_o, 8'hFE, "runs after power-down");
  endtask

  task automatic t_force();
    wr(K_CTRL, 8'h40);
    wr(K_CTRL, 8'h02);
    cyc(8);
    chk(count_o, 8'hFE, "force-on runs");
    wr(K_CTRL, 8'h00);
    chk({7'h00, ctrl_rdata_o[6]}, 8'h01, "force-on sticks");
  endtask

  task automatic t_watchdog();
    wr(K_TB, 8'hFF);
    wr(K_CTRL, 8'h0B);
    wait_sig(0, 1'h1, 20, n);
    // one tick of PS cycles from the refresh edge; the wait starts one edge later
    chk(8'(n), 8'(PS - 1), "expiry reset");
    chk(count_o, 8'hFF, "held at reload");
    wait_sig(0, 1'h0, 20, n);
    chk(8'(n), 8'(PS), "reset pulse length");
    power_down_i = 1'h1;  // stops repeated expiry while the lock is exercised
    wr(K_TB, 8'h00);
    feed();
    wr(K_CTRL, 8'h03);
    chk(count_o, 8'h00, "fed refresh");
    chk({7'h00, ctrl_rdata_o[3]}, 8'h01, "reset enable sticks");
    power_down_i = 1'h0;
    wr(K_U1, wdc_pkg::UNLOCK1_KEY);
    wr(K_U2, 8'h2B);
    wait_sig(0, 1'h1, 4, n);
    wait_sig(0, 1'h0, 20, n);
    wr(K_CTRL, 8'h00);
    chk({7'h00, ctrl_rdata_o[0]}, 8'h01, "unfed write refused");
    wait_sig(0, 1'h1, 4, n);
    wait_sig(0, 1'h0, 20, n);
    chk({7'h00, ctrl_rdata_o[2]}, 8'h01, "sticky flag");
    feed();
    wr(K_CTRL, 8'h05);
    chk({7'h00, ctrl_rdata_o[2]}, 8'h00, "fed flag clear");
    rst_b_i = 1'h0;
    cyc(2);
    rst_b_i = 1'h1;
    chk(ctrl_rdata_o, 8'h00, "power-on clears");
  endtask

  // ----------------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------------
  initial begin
    cyc(10);
    rst_b_i = 1'h1;
    t_reset();
    t_timer();
    t_power_down();
    t_force();
    t_watchdog();
    conclude();
  end
endmodule
